/* File: hw/dcsync_regs.sv */
`timescale 1ns/1ps
`include "dcsync_consts.svh"

module dcsync_regs
  import dcsync_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Register accesses from the two sides.
  input  wire dcsync_acc_s i_net_acc,
  input  wire dcsync_acc_s i_host_acc,
  output logic [7:0]       o_net_rdata,
  output logic             o_net_rvalid,
  output logic [7:0]       o_host_rdata,
  output logic             o_host_rvalid,
  // Configuration and events from the surrounding clock logic.
  input  wire logic        i_host_owns_time,
  input  wire logic        i_wr_ack_en,
  input  wire logic        i_start_written,
  input  wire logic        i_start_in_near,
  input  wire logic        i_first_pulse_a,
  input  wire logic        i_first_pulse_b,
  input  wire logic        i_latch0_irq,
  input  wire logic        i_latch1_irq,
  input  wire logic        i_nv_len_load,
  input  wire logic [15:0] i_nv_len,
  // Settings and commands to the time loop and sync-out core.
  output logic [3:0]       o_tdiff_depth,
  output logic [3:0]       o_speed_depth,
  output logic             o_tdiff_reset,
  output logic             o_speed_filter_reset,
  output logic             o_sync_host_owned,
  output dcsync_act_s      o_act,
  output logic             o_sync_immediate,
  output logic             o_debug_pulse_a,
  output logic             o_debug_pulse_b,
  output logic [15:0]      o_pulse_len,
  output logic             o_ack_mode,
  // Interrupt routing and event request clears.
  output logic             o_latch0_irq_net,
  output logic             o_latch0_irq_host,
  output logic             o_latch1_irq_net,
  output logic             o_latch1_irq_host,
  output logic             o_ale_clear_a,
  output logic             o_ale_clear_b
);

  // ****************************************
  // Reset release
  // ****************************************

  logic       rst_meta_b;
  logic       rst_b;

  // The reset takes hold asynchronously but is released on a clock edge.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_b      <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_b      <= rst_meta_b;
    end
  end

  // ****************************************
  // Register state
  // ****************************************

  logic [3:0]  tdiff_depth;
  logic [3:0]  speed_depth;
  logic [7:0]  owner;
  logic [6:0]  activation;
  logic [6:0]  next_activation;
  logic [15:0] pulse_len;
  logic        pend_a;
  logic        pend_b;
  logic        plaus_fail;
  logic        latch0_host;
  logic        act_wr;
  logic [7:0]  act_wdata;
  logic        act_rise;
  logic        depth_host_ok;

  // Byte write decode shared by both sides.
  function automatic logic wr_hit(input dcsync_acc_s acc, input logic [11:0] ofs);
    wr_hit = acc.wr && (acc.addr == ofs);
  endfunction

  // Read multiplexer; reserved bits and unmapped bytes return zero.
  function automatic logic [7:0] rd_byte(input logic [11:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `DCSYNC_OFS_TDIFF_DEPTH:  v = {4'h0, tdiff_depth};
      `DCSYNC_OFS_SPEED_DEPTH:  v = {4'h0, speed_depth};
      `DCSYNC_OFS_OWNER_CTRL:   v = {owner[7:5], latch0_host, owner[3:0]};
      `DCSYNC_OFS_ACTIVATION:   v = {1'b0, activation};
      `DCSYNC_OFS_PULSE_LEN_LO: v = pulse_len[7:0];
      `DCSYNC_OFS_PULSE_LEN_HI: v = pulse_len[15:8];
      `DCSYNC_OFS_ACT_STATUS:   v = {5'h00, plaus_fail, pend_b, pend_a};
      `DCSYNC_OFS_STATUS_A:     v = {7'h00, pend_a};
      `DCSYNC_OFS_STATUS_B:     v = {7'h00, pend_b};
      default:                  v = 8'h00;
    endcase
    rd_byte = v;
  endfunction

  // Host owning system time also forces latch unit 0 onto the host.
  assign latch0_host   = owner[`DCSYNC_OWN_LATCH0_BIT] | i_host_owns_time;
  assign depth_host_ok = i_host_owns_time;

  // ****************************************
  // Filter depths
  // ****************************************

  // Network writes win when both sides hit the same byte in one cycle.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tdiff_depth          <= `DCSYNC_RST_DEPTH;
      speed_depth          <= `DCSYNC_RST_DEPTH;
      o_tdiff_reset        <= 1'b0;
      o_speed_filter_reset <= 1'b0;
    end
    else
    begin
      o_tdiff_reset        <= 1'b0;
      o_speed_filter_reset <= 1'b0;
      if (wr_hit(i_net_acc, `DCSYNC_OFS_TDIFF_DEPTH))
      begin
        tdiff_depth   <= i_net_acc.wdata[3:0];
        o_tdiff_reset <= 1'b1;
      end
      else if (depth_host_ok && wr_hit(i_host_acc, `DCSYNC_OFS_TDIFF_DEPTH))
      begin
        tdiff_depth   <= i_host_acc.wdata[3:0];
        o_tdiff_reset <= 1'b1;
      end
      if (wr_hit(i_net_acc, `DCSYNC_OFS_SPEED_DEPTH))
      begin
        speed_depth          <= i_net_acc.wdata[3:0];
        o_speed_filter_reset <= 1'b1;
      end
      else if (depth_host_ok && wr_hit(i_host_acc, `DCSYNC_OFS_SPEED_DEPTH))
      begin
        speed_depth          <= i_host_acc.wdata[3:0];
        o_speed_filter_reset <= 1'b1;
      end
    end
  end

  // ****************************************
  // Ownership and interrupt routing
  // ****************************************

  // Only the network side may change ownership; host writes are dropped.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      owner <= `DCSYNC_RST_OWNER;
    end
    else if (wr_hit(i_net_acc, `DCSYNC_OFS_OWNER_CTRL))
    begin
      owner <= i_net_acc.wdata & `DCSYNC_OWNER_MASK;
    end
  end

  // Registered routing costs one cycle of interrupt latency.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_latch0_irq_net  <= 1'b0;
      o_latch0_irq_host <= 1'b0;
      o_latch1_irq_net  <= 1'b0;
      o_latch1_irq_host <= 1'b0;
      o_sync_host_owned <= 1'b0;
    end
    else
    begin
      o_latch0_irq_net  <= i_latch0_irq & ~latch0_host;
      o_latch0_irq_host <= i_latch0_irq & latch0_host;
      o_latch1_irq_net  <= i_latch1_irq & ~owner[`DCSYNC_OWN_LATCH1_BIT];
      o_latch1_irq_host <= i_latch1_irq & owner[`DCSYNC_OWN_LATCH1_BIT];
      o_sync_host_owned <= owner[`DCSYNC_OWN_SYNC_BIT];
    end
  end

  // ****************************************
  // Sync-out activation
  // ****************************************

  // Pick the write of whichever side currently owns the sync-out unit.
  always_comb
  begin
    act_wr    = 1'b0;
    act_wdata = 8'h00;
    if (owner[`DCSYNC_OWN_SYNC_BIT])
    begin
      act_wr    = wr_hit(i_host_acc, `DCSYNC_OFS_ACTIVATION);
      act_wdata = i_host_acc.wdata;
    end
    else
    begin
      act_wr    = wr_hit(i_net_acc, `DCSYNC_OFS_ACTIVATION);
      act_wdata = i_net_acc.wdata;
    end
  end

  // The auto-activation set is applied last so it beats a clearing write.
  always_comb
  begin
    next_activation = activation;
    if (act_wr)
    begin
      next_activation = act_wdata[6:0];
    end
    if (i_start_written && activation[`DCSYNC_ACT_AUTO_BIT])
    begin
      next_activation[`DCSYNC_ACT_UNIT_BIT] = 1'b1;
    end
  end

  assign act_rise = next_activation[`DCSYNC_ACT_UNIT_BIT] & ~activation[`DCSYNC_ACT_UNIT_BIT];

  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      activation <= `DCSYNC_RST_ACTIVATION;
    end
    else
    begin
      activation <= next_activation;
    end
  end

  // The debug bit is never stored, so it always reads back as zero.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_debug_pulse_a  <= 1'b0;
      o_debug_pulse_b  <= 1'b0;
      o_sync_immediate <= 1'b0;
    end
    else
    begin
      o_debug_pulse_a  <= act_wr & act_wdata[`DCSYNC_ACT_DEBUG_BIT]
                          & act_wdata[`DCSYNC_ACT_GEN_A_BIT];
      o_debug_pulse_b  <= act_wr & act_wdata[`DCSYNC_ACT_DEBUG_BIT]
                          & act_wdata[`DCSYNC_ACT_GEN_B_BIT];
      o_sync_immediate <= act_rise & next_activation[`DCSYNC_ACT_PLAUS_BIT]
                          & ~i_start_in_near;
    end
  end

  // Depths reach the core one cycle after their registers; activation is taken from its next value so it lands with the register.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_act         <= '0;
      o_tdiff_depth <= `DCSYNC_RST_DEPTH;
      o_speed_depth <= `DCSYNC_RST_DEPTH;
    end
    else
    begin
      o_act         <= dcsync_act_s'(next_activation);
      o_tdiff_depth <= tdiff_depth;
      o_speed_depth <= speed_depth;
    end
  end

  // ****************************************
  // Activation status
  // ****************************************

  // Activation sets win over a first-pulse clear arriving in the same cycle.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_a     <= 1'b0;
      pend_b     <= 1'b0;
      plaus_fail <= 1'b0;
    end
    else if (act_rise)
    begin
      pend_a     <= next_activation[`DCSYNC_ACT_GEN_A_BIT];
      pend_b     <= next_activation[`DCSYNC_ACT_GEN_B_BIT];
      plaus_fail <= ~i_start_in_near;
    end
    else if (!next_activation[`DCSYNC_ACT_UNIT_BIT])
    begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end
    else
    begin
      if (i_first_pulse_a)
      begin
        pend_a <= 1'b0;
      end
      if (i_first_pulse_b)
      begin
        pend_b <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pulse length
  // ****************************************

  // No bus write reaches this register; only the nonvolatile load does.
  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_len   <= `DCSYNC_RST_PULSE_LEN;
      o_pulse_len <= `DCSYNC_RST_PULSE_LEN;
      o_ack_mode  <= 1'b1;
    end
    else
    begin
      if (i_nv_len_load)
      begin
        pulse_len <= i_nv_len;
      end
      o_pulse_len <= pulse_len;
      o_ack_mode  <= (pulse_len == `DCSYNC_RST_PULSE_LEN);
    end
  end

  // ****************************************
  // Read data and event request clears
  // ****************************************

  always_ff @(posedge i_clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_net_rdata   <= 8'h00;
      o_net_rvalid  <= 1'b0;
      o_host_rdata  <= 8'h00;
      o_host_rvalid <= 1'b0;
      o_ale_clear_a <= 1'b0;
      o_ale_clear_b <= 1'b0;
    end
    else
    begin
      o_net_rdata   <= i_net_acc.rd ? rd_byte(i_net_acc.addr) : 8'h00;
      o_net_rvalid  <= i_net_acc.rd;
      o_host_rdata  <= i_host_acc.rd ? rd_byte(i_host_acc.addr) : 8'h00;
      o_host_rvalid <= i_host_acc.rd;
      // A read clears in read mode, a write clears in acknowledge-by-write mode.
      o_ale_clear_a <= i_wr_ack_en ? wr_hit(i_host_acc, `DCSYNC_OFS_STATUS_A)
                       : (i_host_acc.rd && i_host_acc.addr == `DCSYNC_OFS_STATUS_A);
      o_ale_clear_b <= i_wr_ack_en ? wr_hit(i_host_acc, `DCSYNC_OFS_STATUS_B)
                       : (i_host_acc.rd && i_host_acc.addr == `DCSYNC_OFS_STATUS_B);
    end
  end

endmodule

/* File: hw/dcsync_consts.svh */
// Overview of operation
// - Writing the time-difference filter depth also clears the mean time difference.
// - Writing the speed filter depth also clears the internal speed counter filter.
// - Network may write filter depths; host only when it owns system time.
// - Owner bit 0 hands the sync-out unit to network (0) or host (1).
// - Bits 4 and 5 own latch units; bit 4 reads 1 when host owns time.
// - Each latch interrupt goes to the side its ownership bit selects.
// - Activation bit 0 enables the unit, bits 1 and 2 enable outputs a, b.
// - With auto-activation set, writing the start time sets the unit enable.
// - With extension set, a 32-bit start time is widened to 64 bits.
// - With plausibility check set, a start outside near future fires immediately.
// - Near-future bit picks half clock width (0) or about 2.1 s (1).
// - Debug bit fires one pulse on each enabled output, self-clears, reads 0.
// - Activation writes come only from the side owning the sync-out unit.
// - Pulse length in 10 ns units, read-only, zero at reset, loaded later.
// - Status bits 0 and 1 show first pulse of output a or b pending.
// - Status bit 2 holds the plausibility result taken at activation.
// - Without write acknowledge, host read of status a clears its event request.
`ifndef DCSYNC_CONSTS_SVH
`define DCSYNC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DCSYNC_OFS_TDIFF_DEPTH   12'h934
`define DCSYNC_OFS_SPEED_DEPTH   12'h935
`define DCSYNC_OFS_OWNER_CTRL    12'h980
`define DCSYNC_OFS_ACTIVATION    12'h981
`define DCSYNC_OFS_PULSE_LEN_LO  12'h982
`define DCSYNC_OFS_PULSE_LEN_HI  12'h983
`define DCSYNC_OFS_ACT_STATUS    12'h984
`define DCSYNC_OFS_STATUS_A      12'h98e
`define DCSYNC_OFS_STATUS_B      12'h98f

// ****************************************
// Field positions
// ****************************************
`define DCSYNC_OWN_SYNC_BIT      0
`define DCSYNC_OWN_LATCH0_BIT    4
`define DCSYNC_OWN_LATCH1_BIT    5
`define DCSYNC_ACT_UNIT_BIT      0
`define DCSYNC_ACT_GEN_A_BIT     1
`define DCSYNC_ACT_GEN_B_BIT     2
`define DCSYNC_ACT_AUTO_BIT      3
`define DCSYNC_ACT_EXT_BIT       4
`define DCSYNC_ACT_PLAUS_BIT     5
`define DCSYNC_ACT_NEAR_BIT      6
`define DCSYNC_ACT_DEBUG_BIT     7
`define DCSYNC_DEPTH_MASK        8'h0f
`define DCSYNC_OWNER_MASK        8'h31

// ****************************************
// Reset values and timing
// ****************************************
`define DCSYNC_RST_DEPTH         4'h0
`define DCSYNC_RST_OWNER         8'h00
`define DCSYNC_RST_ACTIVATION    7'h00
`define DCSYNC_RST_PULSE_LEN     16'h0000
`define DCSYNC_PULSE_UNIT_NS     10
`define DCSYNC_NV_PULSE_WORD     16'h0002

`endif

/* File: hw/dcsync_pkg.sv */
package dcsync_pkg;

  // One byte access from either the network side or the local host interface.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dcsync_acc_s;

  // Activation settings handed to the sync-out core.
  typedef struct packed {
    logic near_2s;
    logic plaus_check;
    logic extend_32;
    logic auto_act;
    logic gen_b;
    logic gen_a;
    logic unit_on;
  } dcsync_act_s;

endpackage

/* File: test/dcsync_core_model.sv */
`timescale 1ns/1ps

module dcsync_core_model
  import dcsync_pkg::*;
#(
  parameter int DELAY = 20
)
(
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Settings from the block and first-pulse events back.
  input  wire dcsync_act_s i_act,
  output logic             o_first_a,
  output logic             o_first_b
);
  logic [7:0] cnt;

  // Counts from activation; a real core waits for start time instead.
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt <= 8'h00;
    else if (!i_act.unit_on)
      cnt <= 8'h00;
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h01;
  end

  // Only generated outputs ever report a first pulse.
  assign o_first_a = i_act.gen_a && (cnt == 8'(DELAY));
  assign o_first_b = i_act.gen_b && (cnt == 8'(DELAY));
endmodule

/* File: test/dcsync_regs_assertions.sv */
`timescale 1ns/1ps

module dcsync_regs_assertions
  import dcsync_pkg::*;
(
  // Clock and reset.
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  // Inputs watched.
  input wire dcsync_acc_s i_net_acc,
  input wire dcsync_acc_s i_host_acc,
  input wire logic        i_host_owns_time,
  input wire logic        i_wr_ack_en,
  input wire logic        i_start_written,
  input wire logic        i_latch0_irq,
  // Outputs watched.
  input wire logic        o_tdiff_reset,
  input wire logic        o_speed_filter_reset,
  input wire logic        o_sync_host_owned,
  input wire dcsync_act_s o_act,
  input wire logic        o_sync_immediate,
  input wire logic        o_debug_pulse_a,
  input wire logic [15:0] o_pulse_len,
  input wire logic        o_ack_mode,
  input wire logic        o_latch0_irq_host,
  input wire logic        o_latch0_irq_net,
  input wire logic        o_ale_clear_a
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Bus accesses are not made during the internal reset tail.
  AST_TDIFF_RST: assert property (i_net_acc.wr && i_net_acc.addr == 12'h934
    |=> o_tdiff_reset) else $error("Depth write gave no difference reset.");
  AST_SPEED_RST: assert property (i_net_acc.wr && i_net_acc.addr == 12'h935
    |=> o_speed_filter_reset) else $error("Depth write gave no filter reset.");
  AST_HOST_DEPTH: assert property (i_host_acc.wr && i_host_acc.addr == 12'h934
    && !i_host_owns_time && !i_net_acc.wr |=> !o_tdiff_reset)
    else $error("Host depth write taken without time ownership.");
  AST_LATCH_ROUTE: assert property (i_latch0_irq && i_host_owns_time
    |=> o_latch0_irq_host && !o_latch0_irq_net) else $error("Latch interrupt misrouted.");
  AST_ACT_OWNER: assert property (i_host_acc.wr && i_host_acc.addr == 12'h981
    && !o_sync_host_owned && !i_net_acc.wr && !i_start_written |=> $stable(o_act))
    else $error("Activation write taken from non-owner.");
  AST_DEBUG: assert property (i_net_acc.wr && i_net_acc.addr == 12'h981
    && i_net_acc.wdata[7] && i_net_acc.wdata[1] && !o_sync_host_owned
    |=> o_debug_pulse_a) else $error("Debug write gave no pulse.");
  AST_AUTO: assert property (o_act.auto_act && i_start_written
    |=> o_act.unit_on) else $error("Auto activation did not set unit.");
  AST_IMMED: assert property (o_sync_immediate
    |-> o_act.unit_on && o_act.plaus_check && !$past(o_act.unit_on))
    else $error("Immediate sync without checked activation.");
  AST_ACK_MODE: assert property (o_ack_mode == (o_pulse_len == 16'h0000))
    else $error("Acknowledge mode disagrees with length.");
  AST_ALE: assert property (!i_wr_ack_en && i_host_acc.rd
    && i_host_acc.addr == 12'h98e |=> o_ale_clear_a) else $error("Status read gave no clear.");
  AST_NO_ALE: assert property (!i_host_acc.rd && !i_host_acc.wr
    |=> !o_ale_clear_a) else $error("Event clear without host access.");
endmodule

bind dcsync_regs dcsync_regs_assertions dcsync_regs_assertions_i (.i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b), .i_net_acc(i_net_acc), .i_host_acc(i_host_acc),
  .i_host_owns_time(i_host_owns_time), .i_wr_ack_en(i_wr_ack_en),
  .i_start_written(i_start_written), .i_latch0_irq(i_latch0_irq),
  .o_tdiff_reset(o_tdiff_reset), .o_speed_filter_reset(o_speed_filter_reset),
  .o_sync_host_owned(o_sync_host_owned), .o_act(o_act), .o_sync_immediate(o_sync_immediate),
  .o_debug_pulse_a(o_debug_pulse_a), .o_pulse_len(o_pulse_len), .o_ack_mode(o_ack_mode),
  .o_latch0_irq_host(o_latch0_irq_host), .o_latch0_irq_net(o_latch0_irq_net),
  .o_ale_clear_a(o_ale_clear_a));

/* File: test/dcsync_regs_tb.sv */
`timescale 1ns/1ps

module dcsync_regs_tb;
  import dcsync_pkg::*;
  // ****
  // Signals
  // ****
  logic        i_clk_sys = 1'b0, i_rst_b = 1'b0, owns = 1'b0, ack_en = 1'b0;
  logic        start_wr = 1'b0, in_near = 1'b0, l0 = 1'b0, l1 = 1'b0, nv_ld = 1'b0;
  logic [15:0] nv_len = 16'h0000;
  dcsync_acc_s net = '0, host = '0;
  logic [7:0]  nrd, hrd, d;
  logic [3:0]  td, sd;
  logic        nrv, hrv, tdr, sfr, own_h, imm, dba, dbb, ack, fa, fb;
  logic        l0n, l0h, l1n, l1h, ala, alb;
  dcsync_act_s act;
  logic [15:0] plen, ln;
  logic [31:0] rng = 32'd96768;
  int          n_mismatch = 0, checks = 0, cyc = 0, ale_n = 0;
  logic [11:0] rst_ofs [8] = '{12'h934, 12'h935, 12'h980, 12'h981, 12'h982, 12'h983,
                               12'h984, 12'h9f0};

  dcsync_regs dcsync_regs_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_net_acc(net),
    .i_host_acc(host), .o_net_rdata(nrd), .o_net_rvalid(nrv), .o_host_rdata(hrd),
    .o_host_rvalid(hrv), .i_host_owns_time(owns), .i_wr_ack_en(ack_en),
    .i_start_written(start_wr), .i_start_in_near(in_near), .i_first_pulse_a(fa),
    .i_first_pulse_b(fb), .i_latch0_irq(l0), .i_latch1_irq(l1), .i_nv_len_load(nv_ld),
    .i_nv_len(nv_len), .o_tdiff_depth(td), .o_speed_depth(sd), .o_tdiff_reset(tdr),
    .o_speed_filter_reset(sfr), .o_sync_host_owned(own_h), .o_act(act),
    .o_sync_immediate(imm), .o_debug_pulse_a(dba), .o_debug_pulse_b(dbb),
    .o_pulse_len(plen), .o_ack_mode(ack), .o_latch0_irq_net(l0n), .o_latch0_irq_host(l0h),
    .o_latch1_irq_net(l1n), .o_latch1_irq_host(l1h), .o_ale_clear_a(ala),
    .o_ale_clear_b(alb));

  dcsync_core_model dcsync_core_model_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_act(act), .o_first_a(fa), .o_first_b(fb));

  // Free-running clock.
  always #5 i_clk_sys = ~i_clk_sys;

  // Cycle ceiling and event clear count; a hang ends the run as a failure.
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (ala)
      ale_n++;
    if (cyc > 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // ****
  // Tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Owner readback: bit 4 is forced while the host owns time.
  function automatic logic [7:0] own_exp(input logic [7:0] v, input logic o);
    return (v & 8'h31) | {3'h0, o, 4'h0};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_mismatch++;
  endtask

  // One-cycle request; the answer stands in the cycle after the taking edge.
  task automatic acc(input logic s, input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    if (s)
      host <= '{w, !w, a, v};
    else
      net <= '{w, !w, a, v};
    @(posedge i_clk_sys);
    net <= '0;
    host <= '0;
    #1;
  endtask

  task automatic rd_chk(input logic s, input logic [11:0] a, input logic [7:0] e);
    acc(s, 1'b0, a, 8'h00);
    chk({s ? hrv : nrv, 7'h00, s ? hrd : nrd}, {8'h80, e});
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    foreach (rst_ofs[k])
      rd_chk(1'b0, rst_ofs[k], 8'h00);
    chk({15'h0, ack}, 16'h0001);
    rng = xs(rng);
    acc(1'b0, 1'b1, 12'h934, rng[7:0]);
    chk({15'h0, tdr}, 16'h0001);
    rd_chk(1'b1, 12'h934, rng[7:0] & 8'h0f);
    acc(1'b1, 1'b1, 12'h935, 8'h0a);
    rd_chk(1'b0, 12'h935, 8'h00);
    owns <= 1'b1;
    acc(1'b1, 1'b1, 12'h935, rng[15:8]);
    rd_chk(1'b0, 12'h935, rng[15:8] & 8'h0f);
    d = rng[23:16] & 8'hfe;
    acc(1'b0, 1'b1, 12'h980, d);
    acc(1'b1, 1'b1, 12'h980, 8'hff);
    rd_chk(1'b1, 12'h980, own_exp(d, 1'b1));
    l0 <= 1'b1;
    l1 <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({12'h0, l0h, l0n, l1h, l1n}, {12'h0, 2'b10, d[5], !d[5]});
    owns <= 1'b0;
    rd_chk(1'b0, 12'h980, own_exp(d, 1'b0));
    acc(1'b1, 1'b1, 12'h981, 8'h07);
    rd_chk(1'b0, 12'h981, 8'h00);
    acc(1'b0, 1'b1, 12'h981, 8'ha7);
    chk({14'h0, dba, dbb}, 16'h0003);
    rd_chk(1'b0, 12'h981, 8'h27);
    rd_chk(1'b1, 12'h984, 8'h07);
    repeat (30) @(posedge i_clk_sys);
    rd_chk(1'b0, 12'h984, 8'h04);
    acc(1'b0, 1'b1, 12'h981, 8'h08);
    start_wr <= 1'b1;
    @(posedge i_clk_sys);
    start_wr <= 1'b0;
    rd_chk(1'b1, 12'h981, 8'h09);
    for (int k = 0; k < 7; k++)
    begin
      acc(1'b0, 1'b1, 12'h981, 8'h01 << k);
      chk({9'h0, act}, 16'h0001 << k);
    end
    // A checked activation with the start outside the near future fires at once.
    acc(1'b0, 1'b1, 12'h981, 8'h21);
    chk({15'h0, imm}, 16'h0001);
    acc(1'b0, 1'b1, 12'h981, 8'h00);
    rng = xs(rng);
    ln = rng[15:0] | 16'h0001;
    nv_len <= ln;
    nv_ld <= 1'b1;
    @(posedge i_clk_sys);
    nv_ld <= 1'b0;
    acc(1'b0, 1'b1, 12'h983, ~ln[15:8]);
    rd_chk(1'b0, 12'h982, ln[7:0]);
    rd_chk(1'b1, 12'h983, ln[15:8]);
    chk({15'h0, ack}, 16'h0000);
    chk(plen, ln);
    rd_chk(1'b0, 12'h98e, 8'h00);
    chk(16'(ale_n), 16'h0000);
    rd_chk(1'b1, 12'h98e, 8'h00);
    // The clear pulse is counted at the edge after it appears.
    @(posedge i_clk_sys);
    #1;
    chk(16'(ale_n), 16'h0001);
    test_done();
  end
endmodule
